/* design/dual_timer_counter_unit.sv */
/*
  Two 8/16-bit timer/counters with Avalon-MM register access, overflow
  toggle/PWM drive on the count pins and a maskable interrupt.
  Assumes one 10 MHz clock, synchronous active-low reset, and a resolved
  wire outside that combines the pin output enables with the far side.
*/
// Our own choices: register access over Avalon-MM and the address map.
`include "timer_pair_map.svh"

// Notes on behaviour
// - A machine cycle is two core clocks and paces all timing.
// - Timer function adds one to the count every machine cycle.
// - Counter function adds one per falling edge of the count pin.
// - Count pin sampled once per machine cycle; source holds levels.
// - Modes 0,1,2,3,6 exist; only mode 3 differs between timers.
// - Mode 0 is an 8-bit counter behind a divide-by-32 prescaler.
// - Mode 1 is mode 0 using all sixteen count bits.
// - Mode 2 is an 8-bit counter reloading itself on overflow.
// - Timer 1 in mode 3 stops counting.
// - Timer 0 in mode 3 becomes two independent 8-bit counters.
// - With timer 0 in mode 3 the serial baud source stays usable.
// - Mode 6 is a PWM with a 256 timer clock period.
// - With toggling on, each overflow inverts the pin output; in mode 6 the pin shows the PWM level.
// - Toggle output shares the pin used as the count input.
// - Toggle output stays high until the first overflow after enable.
// - Third mode bit per timer lives in an auxiliary register.
// - Run bits and overflow flags share a control register.
module dual_timer_counter_unit
  import timer_pair_pkg::*;
#(
  parameter int CLKS_PER_MC = `TMR_CLKS_PER_MC
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   reset_n_in,
  input  wire logic [`TMR_ADDR_W-1:0] avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic      [31:0]            avs_readdata_out,
  output logic                        avs_waitrequest_out,
  input  wire logic                   count_pin_zero_in,
  input  wire logic                   count_pin_one_in,
  output logic                        count_pin_zero_out,
  output logic                        count_pin_zero_oe_out,
  output logic                        count_pin_one_out,
  output logic                        count_pin_one_oe_out,
  output logic                        baud_tick_out,
  output logic                        irq_out
);

  if (CLKS_PER_MC < 2 || CLKS_PER_MC > 15) begin : g_bad_div
    $error("CLKS_PER_MC must lie between 2 and 15");
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  function automatic tmr_mode_e mode_of(input logic b2,
                                        input logic [1:0] m);
    mode_of = tmr_mode_e'({b2, m});
  endfunction : mode_of

  // One counting step of a timer in the given mode
  function automatic cnt_s step(input tmr_mode_e m,
                                input logic [7:0] hi,
                                input logic [7:0] lo);
    cnt_s        r;
    logic [5:0]  p;
    logic [16:0] w;
    r = '{ovf: 1'b0, hi: hi, lo: lo};
    p = 6'h00;
    w = 17'h00000;
    case (m)
      MODE_13BIT: begin
        p = {1'b0, lo[4:0]} + 6'h01;
        r.lo = {lo[7:5], p[4:0]};
        if (p[5]) begin
          {r.ovf, r.hi} = {1'b0, hi} + 9'h001;
        end
      end
      MODE_16BIT: begin
        w = {1'b0, hi, lo} + 17'h00001;
        {r.ovf, r.hi, r.lo} = w;
      end
      MODE_RELOAD: begin
        {r.ovf, r.lo} = {1'b0, lo} + 9'h001;
        if (r.ovf) begin
          r.lo = hi;
        end
      end
      default: begin
        {r.ovf, r.lo} = {1'b0, lo} + 9'h001;
      end
    endcase
    step = r;
  endfunction : step

  bus_state_e  bus_state_reg;
  logic [31:0] rdata_reg;
  logic [3:0]  div_reg;
  logic        mc_tick;
  logic [1:0]  meta_reg;
  logic [1:0]  sync_reg;
  logic [1:0]  samp_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  aux_reg;
  logic [1:0]  run_reg;
  logic [1:0]  flag_reg;
  logic [15:0] cnt0_reg;
  logic [15:0] cnt1_reg;
  logic [1:0]  tog_en_reg;
  logic [1:0]  tog_reg;
  logic [1:0]  pin_out_reg;
  logic [1:0]  pin_oe_reg;
  logic [1:0]  istat_reg;
  logic [1:0]  imask_reg;
  logic        irq_reg;
  logic        baud_reg;

  // Bus decode
  wire         accept   = (bus_state_reg == BUS_ANSWER) &&
                          (avs_read_in || avs_write_in);
  wire         wr_acc   = accept && avs_write_in;
  wire         rd_acc   = accept && avs_read_in;
  wire         be_lo    = avs_byteenable_in[0];
  wire         be_hi    = avs_byteenable_in[1];
  wire [7:0]   wb       = avs_writedata_in[7:0];
  wire         wr_mode  = wr_acc && be_lo &&
                          avs_address_in == `TMR_OFS_MODE;
  wire         wr_ctrl  = wr_acc && be_lo &&
                          avs_address_in == `TMR_OFS_CTRL;
  wire         wr_aux   = wr_acc && be_lo &&
                          avs_address_in == `TMR_OFS_AUX;
  wire         wr_tog   = wr_acc && be_lo &&
                          avs_address_in == `TMR_OFS_TOGGLE;
  wire         wr_imask = wr_acc && be_lo &&
                          avs_address_in == `TMR_OFS_IMASK;
  wire         cnt0_wr  = wr_acc && avs_address_in == `TMR_OFS_CNT0;
  wire         cnt1_wr  = wr_acc && avs_address_in == `TMR_OFS_CNT1;
  wire         istat_rd = rd_acc && avs_address_in == `TMR_OFS_ISTAT;

  // Mode decode, three bits per timer
  wire tmr_mode_e mode0_w = mode_of(aux_reg[`TMR_AUX_B2_0],
    mode_reg[`TMR_MODE_T0_MSB:`TMR_MODE_T0_LSB]);
  wire tmr_mode_e mode1_w = mode_of(aux_reg[`TMR_AUX_B2_1],
    mode_reg[`TMR_MODE_T1_MSB:`TMR_MODE_T1_LSB]);
  wire         ct0      = mode_reg[`TMR_MODE_T0_CT];
  wire         ct1      = mode_reg[`TMR_MODE_T1_CT];
  wire         t0_split = mode0_w == MODE_SPLIT;
  wire         t1_stop  = mode1_w == MODE_SPLIT;
  wire [1:0]   pwm_w    = {mode1_w == MODE_PWM, mode0_w == MODE_PWM};

  // Falling edge seen between two machine-cycle samples
  wire [1:0]   fall_w   = {2{mc_tick}} & samp_reg & ~sync_reg;

  // Timer 0
  wire         inc0     = run_reg[0] && (ct0 ? fall_w[0] : mc_tick);
  wire cnt_s   st0      = step(mode0_w, cnt0_reg[15:8], cnt0_reg[7:0]);
  wire         ovf0     = inc0 && st0.ovf;
  // Upper half as a second 8-bit timer, borrowing timer 1's run bit
  wire         inc0h    = t0_split && run_reg[1] && mc_tick;
  wire         ovf0h    = inc0h && (&cnt0_reg[15:8]);
  wire [7:0]   hi0_w    = t0_split ? cnt0_reg[15:8] + 8'h01 : st0.hi;
  wire         hi0_en   = t0_split ? inc0h : inc0;

  // Timer 1 free-runs as the baud source while timer 0 owns its run bit
  wire         run1_w   = t0_split ? 1'b1 : run_reg[1];
  wire         inc1     = run1_w && !t1_stop &&
                          (ct1 ? fall_w[1] : mc_tick);
  wire cnt_s   st1      = step(mode1_w, cnt1_reg[15:8], cnt1_reg[7:0]);
  wire         ovf1     = inc1 && st1.ovf;

  wire [1:0]   flag_set = {t0_split ? ovf0h : ovf1, ovf0};
  wire [1:0]   tog_evt  = {ovf1, ovf0};

  // Read data
  wire [7:0]   ctrl_rd  = {flag_reg[1], run_reg[1], flag_reg[0],
                           run_reg[0], 4'h0};
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address_in)
      `TMR_OFS_MODE:   rd_mux = {24'h000000, mode_reg};
      `TMR_OFS_CTRL:   rd_mux = {24'h000000, ctrl_rd};
      `TMR_OFS_AUX:    rd_mux = {24'h000000, aux_reg};
      `TMR_OFS_CNT0:   rd_mux = {16'h0000, cnt0_reg};
      `TMR_OFS_CNT1:   rd_mux = {16'h0000, cnt1_reg};
      `TMR_OFS_TOGGLE: rd_mux = {30'h0, tog_en_reg};
      `TMR_OFS_ISTAT:  rd_mux = {30'h0, istat_reg};
      `TMR_OFS_IMASK:  rd_mux = {30'h0, imask_reg};
      default:         rd_mux = 32'h00000000;
    endcase
  end

  // Next values
  logic [15:0] cnt0_next;
  logic [15:0] cnt1_next;
  logic [1:0]  flag_next;
  logic [1:0]  tog_next;
  logic [1:0]  pwm_lvl;
  always_comb begin
    cnt0_next = cnt0_reg;
    if (hi0_en) cnt0_next[15:8] = hi0_w;
    if (inc0) cnt0_next[7:0] = st0.lo;
    if (cnt0_wr && be_hi) cnt0_next[15:8] = avs_writedata_in[15:8];
    if (cnt0_wr && be_lo) cnt0_next[7:0] = wb;
    cnt1_next = cnt1_reg;
    if (inc1) cnt1_next = {st1.hi, st1.lo};
    if (cnt1_wr && be_hi) cnt1_next[15:8] = avs_writedata_in[15:8];
    if (cnt1_wr && be_lo) cnt1_next[7:0] = wb;
    // A set in the cycle of a clearing write wins
    flag_next = wr_ctrl ? {wb[`TMR_CTRL_FLAG1], wb[`TMR_CTRL_FLAG0]}
                        : flag_reg;
    flag_next = flag_next | flag_set;
    // Disabled toggles sit at one, so enabling starts high
    tog_next = (tog_reg ^ tog_evt) | ~tog_en_reg;
    // High while the low byte is below the duty byte
    pwm_lvl = {cnt1_reg[7:0] < cnt1_reg[15:8],
               cnt0_reg[7:0] < cnt0_reg[15:8]};
  end

  // Bus handshake: answer one cycle after the request rises
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      bus_state_reg <= BUS_WAIT;
      rdata_reg     <= 32'h00000000;
    end else begin
      case (bus_state_reg)
        BUS_WAIT: begin
          if (avs_read_in || avs_write_in) bus_state_reg <= BUS_ANSWER;
          if (avs_read_in) rdata_reg <= rd_mux;
        end
        BUS_ANSWER: bus_state_reg <= BUS_WAIT;
        default:    bus_state_reg <= BUS_WAIT;
      endcase
    end
  end

  // Machine-cycle enable and pin synchronisers
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      div_reg  <= 4'h0;
      mc_tick  <= 1'b0;
      meta_reg <= 2'h3;
      sync_reg <= 2'h3;
      samp_reg <= 2'h3;
    end else begin
      div_reg  <= (div_reg == 4'(CLKS_PER_MC - 1)) ? 4'h0
                                                  : div_reg + 4'h1;
      mc_tick  <= div_reg == 4'(CLKS_PER_MC - 2);
      meta_reg <= {count_pin_one_in, count_pin_zero_in};
      sync_reg <= meta_reg;
      if (mc_tick) samp_reg <= sync_reg;
    end
  end

  // Software-visible control
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      mode_reg   <= `TMR_RST_BYTE;
      aux_reg    <= `TMR_RST_BYTE;
      run_reg    <= 2'h0;
      flag_reg   <= 2'h0;
      tog_en_reg <= 2'h0;
      imask_reg  <= 2'h0;
      istat_reg  <= 2'h0;
      irq_reg    <= 1'b0;
    end else begin
      if (wr_mode) mode_reg <= wb;
      if (wr_aux) aux_reg <= wb &
        (8'h01 << `TMR_AUX_B2_0 | 8'h01 << `TMR_AUX_B2_1);
      if (wr_ctrl) run_reg <= {wb[`TMR_CTRL_RUN1], wb[`TMR_CTRL_RUN0]};
      if (wr_tog) tog_en_reg <= wb[1:0];
      if (wr_imask) imask_reg <= wb[1:0];
      flag_reg  <= flag_next;
      istat_reg <= flag_set | (istat_rd ? 2'h0 : istat_reg);
      irq_reg   <= |(istat_reg & imask_reg);
    end
  end

  // Counts and pin drive
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      cnt0_reg    <= `TMR_RST_CNT;
      cnt1_reg    <= `TMR_RST_CNT;
      tog_reg     <= 2'h3;
      pin_out_reg <= 2'h3;
      pin_oe_reg  <= 2'h0;
      baud_reg    <= 1'b0;
    end else begin
      cnt0_reg    <= cnt0_next;
      cnt1_reg    <= cnt1_next;
      tog_reg     <= tog_next;
      pin_out_reg <= (pwm_w & pwm_lvl) | (~pwm_w & tog_next);
      pin_oe_reg  <= tog_en_reg | pwm_w;
      baud_reg    <= ovf1;
    end
  end

  assign avs_readdata_out      = rdata_reg;
  assign avs_waitrequest_out   = bus_state_reg;
  assign count_pin_zero_out    = pin_out_reg[0];
  assign count_pin_one_out     = pin_out_reg[1];
  assign count_pin_zero_oe_out = pin_oe_reg[0];
  assign count_pin_one_oe_out  = pin_oe_reg[1];
  assign baud_tick_out         = baud_reg;
  assign irq_out               = irq_reg;

  // The tick spacing checked here holds for the default divider
  property p_mc_tick;
    mc_tick |=> !mc_tick ##1 mc_tick;
  endproperty
  a_mc_tick: assert property (p_mc_tick)
    else $error("machine cycle tick spacing wrong");

  property p_timer_inc;
    mode0_w == MODE_16BIT && !ct0 && run_reg[0] && mc_tick && !cnt0_wr
      |=> cnt0_reg == $past(cnt0_reg) + 16'h0001;
  endproperty
  a_timer_inc: assert property (p_timer_inc)
    else $error("timer did not step on machine cycle");

  property p_counter_inc;
    mode0_w == MODE_16BIT && ct0 && run_reg[0] && fall_w[0] && !cnt0_wr
      |=> cnt0_reg == $past(cnt0_reg) + 16'h0001;
  endproperty
  a_counter_inc: assert property (p_counter_inc)
    else $error("counter missed a falling edge");

  property p_sample_only_on_tick;
    mode0_w == MODE_16BIT && ct0 && !mc_tick && !cnt0_wr
      |=> $stable(cnt0_reg);
  endproperty
  a_sample_only_on_tick: assert property (p_sample_only_on_tick)
    else $error("counter moved between samples");

  property p_prescale;
    mode0_w == MODE_13BIT && inc0 && cnt0_reg[4:0] == 5'h1f && !cnt0_wr
      |=> cnt0_reg[4:0] == 5'h00 &&
          cnt0_reg[15:8] == $past(cnt0_reg[15:8]) + 8'h01;
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler carry lost");

  property p_reload;
    mode0_w == MODE_RELOAD && inc0 && cnt0_reg[7:0] == 8'hff && !cnt0_wr
      |=> cnt0_reg[7:0] == $past(cnt0_reg[15:8]) && flag_reg[0];
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload or flag missing");

  property p_t1_stop;
    t1_stop && !cnt1_wr |=> $stable(cnt1_reg);
  endproperty
  a_t1_stop: assert property (p_t1_stop)
    else $error("timer 1 counted in mode 3");

  property p_split_hi;
    t0_split && run_reg[1] && mc_tick && !cnt0_wr
      |=> cnt0_reg[15:8] == $past(cnt0_reg[15:8]) + 8'h01;
  endproperty
  a_split_hi: assert property (p_split_hi)
    else $error("split upper counter did not step");

  property p_toggle;
    tog_en_reg[0] && $past(tog_en_reg[0]) && ovf0 && !pwm_w[0]
      |=> count_pin_zero_out == !$past(count_pin_zero_out);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("overflow did not toggle pin");

  property p_toggle_start;
    $rose(tog_en_reg[0]) |-> tog_reg[0] ##1 count_pin_zero_out;
  endproperty
  a_toggle_start: assert property (p_toggle_start)
    else $error("toggle output not high at enable");

  c_reload: cover property (mode0_w == MODE_RELOAD && ovf0);
  c_split: cover property (t0_split && ovf0h);
  c_irq: cover property ($rose(irq_out));
  c_pwm: cover property (pwm_w[1] && $fell(count_pin_one_out));

endmodule : dual_timer_counter_unit

/* design/timer_pair_map.svh */
/*
  Register offsets, bit positions and reset values of the dual
  timer/counter unit. Assumes a byte-addressed Avalon-MM slave port with
  32-bit data, one register per aligned word.
*/
`ifndef TIMER_PAIR_MAP_SVH
`define TIMER_PAIR_MAP_SVH

`define TMR_ADDR_W       5
`define TMR_OFS_MODE     5'h00
`define TMR_OFS_CTRL     5'h04
`define TMR_OFS_AUX      5'h08
`define TMR_OFS_CNT0     5'h0c
`define TMR_OFS_CNT1     5'h10
`define TMR_OFS_TOGGLE   5'h14
`define TMR_OFS_ISTAT    5'h18
`define TMR_OFS_IMASK    5'h1c

// Mode register: low nibble timer 0, high nibble timer 1
`define TMR_MODE_T0_LSB  0
`define TMR_MODE_T0_MSB  1
`define TMR_MODE_T0_CT   2
`define TMR_MODE_T1_LSB  4
`define TMR_MODE_T1_MSB  5
`define TMR_MODE_T1_CT   6

// Control register
`define TMR_CTRL_RUN0    4
`define TMR_CTRL_FLAG0   5
`define TMR_CTRL_RUN1    6
`define TMR_CTRL_FLAG1   7

// Auxiliary mode register
`define TMR_AUX_B2_0     0
`define TMR_AUX_B2_1     4

`define TMR_RST_BYTE     8'h00
`define TMR_RST_CNT      16'h0000
`define TMR_CLKS_PER_MC  2

`endif

/* design/timer_pair_pkg.sv */
/*
  Types of the dual timer/counter unit: operating modes, bus state and
  the result of one counting step. Assumes timer_pair_map.svh for numbers.
*/
package timer_pair_pkg;

  typedef enum logic [2:0] {
    MODE_13BIT  = 3'h0,
    MODE_16BIT  = 3'h1,
    MODE_RELOAD = 3'h2,
    MODE_SPLIT  = 3'h3,
    MODE_PWM    = 3'h6
  } tmr_mode_e;

  typedef enum logic {
    BUS_WAIT   = 1'b1,
    BUS_ANSWER = 1'b0
  } bus_state_e;

  typedef struct packed {
    logic       ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } cnt_s;

endpackage : timer_pair_pkg

/* verification/count_pin_source.sv */
/*
  Far-side event source on one count pin: a burst of falling edges.
  Assumes a pull-up on the resolved pin wire once it lets go of the line.
*/
module count_pin_source (
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       start_in,
  input  wire logic [7:0] edges_in,
  input  wire logic [3:0] hold_in,
  output logic            level_out,
  output logic            drive_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] phase_reg;
  logic [3:0] hold_reg;

  // A long hold_in models a slow source, a short one a prompt source
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in || start_in) begin
      phase_reg <= start_in ? {edges_in, 1'b0} : 9'h000;
      hold_reg  <= hold_in;
      level_out <= 1'b1;
      drive_out <= start_in;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
    end else if (phase_reg != 9'h000) begin
      phase_reg <= phase_reg - 9'h001;
      hold_reg  <= hold_in;
      level_out <= ~level_out;
    end else begin
      drive_out <= 1'b0;
    end
  end
endmodule : count_pin_source

/* verification/dual_timer_counter_unit_test.sv */
/*
  Self-checking bench of the dual timer/counter unit: register access,
  modes, counting, toggle/PWM pins and the interrupt.
  Assumes the design defaults and one pull-up on each count pin wire.
*/
`include "timer_pair_map.svh"
module dual_timer_counter_unit_test import timer_pair_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk_in, reset_n_in, rd_q, wr_q, baud, irq;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  logic        wreq, p0_out, p0_oe, p1_out, p1_oe;
  logic [1:0]  s_start, s_lvl, s_drv;
  logic [7:0]  s_edges;
  logic [3:0]  s_hold, be;
  wire         pin0, pin1;
  int          err_count, check_count, baud_cnt;

  // Pull-up wins when neither side drives
  assign pin0 = p0_oe ? p0_out : (s_drv[0] ? s_lvl[0] : 1'b1);
  assign pin1 = p1_oe ? p1_out : (s_drv[1] ? s_lvl[1] : 1'b1);

  dual_timer_counter_unit dut_u (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .avs_address_in(addr), .avs_read_in(rd_q), .avs_write_in(wr_q),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .count_pin_zero_in(pin0), .count_pin_one_in(pin1),
    .count_pin_zero_out(p0_out), .count_pin_zero_oe_out(p0_oe),
    .count_pin_one_out(p1_out), .count_pin_one_oe_out(p1_oe),
    .baud_tick_out(baud), .irq_out(irq));

  count_pin_source src0_u (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .start_in(s_start[0]), .edges_in(s_edges),
    .hold_in(s_hold), .level_out(s_lvl[0]), .drive_out(s_drv[0]));
  count_pin_source src1_u (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .start_in(s_start[1]), .edges_in(s_edges),
    .hold_in(s_hold), .level_out(s_lvl[1]), .drive_out(s_drv[1]));

  always #50 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (baud === 1'b1) baud_cnt++;

  task automatic end_sim;
    if (err_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  task automatic fail(input string msg);
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask : tick

  // Request held until the edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d, output logic [31:0] q);
    int n;
    @(posedge core_clk_in);
    addr  <= a;
    wdata <= {16'h0000, d};
    rd_q  <= !w;
    wr_q  <= w;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
      if (n > 20) begin
        fail("bus timeout");
        end_sim();
      end
    end while (wreq !== 1'b0);
    q = rdata;
    rd_q <= 1'b0;
    wr_q <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    logic [31:0] r;
    xfer(1'b0, a, 16'h0000, r);
    check_count++;
    if (r[31:16] !== 16'h0000) fail("upper read bits set");
    q = r[15:0];
  endtask : rd

  task automatic clear_all;
    logic [15:0] q;
    wr(`TMR_OFS_CTRL, 16'h0000);
    wr(`TMR_OFS_MODE, 16'h0000);
    wr(`TMR_OFS_AUX, 16'h0000);
    wr(`TMR_OFS_TOGGLE, 16'h0000);
    wr(`TMR_OFS_IMASK, 16'h0000);
    // Status is sticky: a read drops what earlier scenarios left behind
    rd(`TMR_OFS_ISTAT, q);
  endtask : clear_all

  task automatic t_reset;
    logic [15:0] q;
    if (wreq !== 1'b1 || irq !== 1'b0 || p0_oe !== 1'b0) fail("idle outs");
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), q);
      if (q !== 16'h0000) fail("reset value");
    end
    rd(5'h02, q);
    if (q !== 16'h0000) fail("unmapped read");
    // Each lane of a count register is written on its own
    wr(`TMR_OFS_CNT1, 16'h1234);
    be <= 4'h2;
    wr(`TMR_OFS_CNT1, 16'habcd);
    be <= 4'h1;
    wr(`TMR_OFS_CNT1, 16'h5678);
    be <= 4'hf;
    rd(`TMR_OFS_CNT1, q);
    if (q !== 16'hab78) fail("byte lanes");
  endtask : t_reset

  // Runs timer 0 for about five machine cycles from a preset
  task automatic t_mode(input tmr_mode_e md, input logic [15:0] pre,
                        input logic [7:0] hi, input logic [7:0] lo,
                        input logic flag);
    logic [15:0] q;
    logic [7:0]  d;
    wr(`TMR_OFS_AUX, {15'h0000, md[2]});
    wr(`TMR_OFS_MODE, {14'h0000, md[1:0]});
    wr(`TMR_OFS_CNT0, pre);
    wr(`TMR_OFS_CTRL, 16'h0010);
    tick(4);
    rd(`TMR_OFS_CTRL, q);
    if (q[5] !== flag) fail("overflow flag");
    wr(`TMR_OFS_CTRL, 16'h0000);
    rd(`TMR_OFS_CNT0, q);
    d = q[7:0] - lo;
    if (q[15:8] !== hi || (d <= 8'h04) !== 1'b1) fail("count");
  endtask : t_mode

  task automatic t_counter(input int t, input logic [3:0] hold);
    logic [15:0] q;
    int n;
    wr(`TMR_OFS_MODE, t ? 16'h0050 : 16'h0005);
    wr(t ? `TMR_OFS_CNT1 : `TMR_OFS_CNT0, 16'h0000);
    wr(`TMR_OFS_CTRL, t ? 16'h0040 : 16'h0010);
    s_hold <= hold;
    s_start[t] <= 1'b1;
    @(posedge core_clk_in);
    s_start[t] <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
      if (n > 400) begin
        fail("source timeout");
        end_sim();
      end
    end while (s_drv[t] !== 1'b0);
    tick(10);
    wr(`TMR_OFS_CTRL, 16'h0000);
    rd(t ? `TMR_OFS_CNT1 : `TMR_OFS_CNT0, q);
    if (q !== {8'h00, s_edges}) fail("event count");
  endtask : t_counter

  task automatic t_mode3;
    logic [15:0] q;
    wr(`TMR_OFS_MODE, 16'h0030);
    wr(`TMR_OFS_CNT1, 16'h1234);
    wr(`TMR_OFS_CTRL, 16'h0040);
    tick(10);
    rd(`TMR_OFS_CNT1, q);
    if (q !== 16'h1234) fail("timer 1 mode 3 counts");
    wr(`TMR_OFS_MODE, 16'h0003);
    wr(`TMR_OFS_CNT0, 16'hff10);
    tick(4);
    rd(`TMR_OFS_CTRL, q);
    if (q[7:5] !== 3'b110) fail("split high byte flag");
    wr(`TMR_OFS_CTRL, 16'h0000);
    rd(`TMR_OFS_CNT0, q);
    if (q[7:0] !== 8'h10 || (q[15:8] <= 8'h06) !== 1'b1) fail("split");
  endtask : t_mode3

  task automatic t_toggle;
    int n;
    logic last;
    wr(`TMR_OFS_MODE, 16'h0002);
    wr(`TMR_OFS_CNT0, 16'hfcfc);
    wr(`TMR_OFS_TOGGLE, 16'h0001);
    tick(2);
    if (p0_oe !== 1'b1 || pin0 !== 1'b1) fail("toggle idle");
    wr(`TMR_OFS_CTRL, 16'h0010);
    n = 0;
    last = pin0;
    repeat (80) begin
      @(posedge core_clk_in);
      if (pin0 !== last) n++;
      last = pin0;
    end
    // Four ticks a period, eight clocks between toggles
    if (n < 9 || n > 11) fail("toggle count");
  endtask : t_toggle

  task automatic t_pwm;
    int n;
    wr(`TMR_OFS_AUX, 16'h0010);
    wr(`TMR_OFS_MODE, 16'h0020);
    wr(`TMR_OFS_CNT1, 16'h4000);
    wr(`TMR_OFS_CTRL, 16'h0040);
    tick(4);
    n = 0;
    repeat (512) begin
      @(posedge core_clk_in);
      if (pin1 === 1'b1) n++;
    end
    if (p1_oe !== 1'b1 || n < 124 || n > 132) fail("pwm duty");
  endtask : t_pwm

  task automatic t_irq;
    logic [15:0] q;
    int n, b;
    wr(`TMR_OFS_IMASK, 16'h0002);
    wr(`TMR_OFS_MODE, 16'h0010);
    wr(`TMR_OFS_CNT1, 16'hfffe);
    b = baud_cnt;
    wr(`TMR_OFS_CTRL, 16'h0040);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge core_clk_in);
      n++;
      if (n > 20) begin
        fail("irq timeout");
        end_sim();
      end
    end
    wr(`TMR_OFS_CTRL, 16'h0000);
    if (baud_cnt - b != 1) fail("baud pulse count");
    rd(`TMR_OFS_ISTAT, q);
    if (q !== 16'h0002) fail("status bit");
    rd(`TMR_OFS_ISTAT, q);
    if (q !== 16'h0000) fail("status not cleared");
    tick(2);
    if (irq !== 1'b0) fail("irq stuck");
    wr(`TMR_OFS_IMASK, 16'h0000);
    wr(`TMR_OFS_CNT1, 16'hfffe);
    wr(`TMR_OFS_CTRL, 16'h0040);
    tick(12);
    if (irq !== 1'b0) fail("masked irq");
    rd(`TMR_OFS_ISTAT, q);
    if (q[1] !== 1'b1) fail("masked status");
  endtask : t_irq

  initial begin
    core_clk_in = 1'b0;
    reset_n_in = 1'b0;
    {rd_q, wr_q, addr, wdata} = '0;
    be = 4'hf;
    s_start = 2'b00;
    s_edges = 8'h07;
    s_hold = 4'h6;
    err_count = 0;
    check_count = 0;
    baud_cnt = 0;
    tick(12);
    reset_n_in <= 1'b1;
    tick(1);
    t_reset();
    t_mode(MODE_13BIT, 16'hff1f, 8'h00, 8'h02, 1'b1);
    t_mode(MODE_13BIT, 16'h001f, 8'h01, 8'h02, 1'b0);
    t_mode(MODE_16BIT, 16'hffff, 8'h00, 8'h02, 1'b1);
    t_mode(MODE_16BIT, 16'h0000, 8'h00, 8'h03, 1'b0);
    t_mode(tmr_mode_e'(3'h4), 16'h12ff, 8'h12, 8'h02, 1'b1);
    t_mode(MODE_PWM, 16'h40ff, 8'h40, 8'h02, 1'b1);
    t_mode(MODE_RELOAD, 16'ha0ff, 8'ha0, 8'ha2, 1'b1);
    clear_all();
    t_counter(0, 4'h6);
    t_counter(1, 4'h9);
    clear_all();
    t_mode3();
    clear_all();
    t_toggle();
    clear_all();
    t_pwm();
    clear_all();
    t_irq();
    reset_n_in <= 1'b0;
    tick(2);
    reset_n_in <= 1'b1;
    tick(1);
    t_reset();
    end_sim();
  end
endmodule : dual_timer_counter_unit_test
